/* File: design/tecd_pkg.sv */
// Purpose: Shared types and constants for the timer external clock block
// Assumes: One peripheral clock, synchronous inputs
// Notes: Mode codes select how each timer reacts to its pin pair
package tecd_pkg;

    localparam int TECD_WIDTH = 16;
    localparam logic [15:0] TECD_COUNT_RST = 16'h0000;
    localparam logic [1:0] TECD_PINS_RST = 2'h0;

    // Counting modes per timer
    typedef enum logic [1:0] {
        TECD_MODE_OFF  = 2'h0,
        TECD_MODE_EDGE = 2'h1,
        TECD_MODE_QUAD = 2'h2
    } tecd_mode_e;

    // One timer's pin pair from the outside source
    typedef struct packed {
        logic ext_clock;
        logic ext_direction;
    } tecd_pins_s;

endpackage

/* File: design/tecd_timer_ext.sv */
// Purpose: External clock, direction and quadrature counting for two timers
// Assumes: Pins already synchronous to ref_clk; rst_n synchronous active low
// Notes: Count is WIDTH bits (16 by default) and wraps in both directions
`timescale 1ns/1ps
`default_nettype none

module tecd_timer_ext #(
    parameter int WIDTH = tecd_pkg::TECD_WIDTH
) (
    input wire logic ref_clk, // Peripheral clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic first_timer_ext_clock, // Timer one external clock pin
    input wire logic first_timer_ext_direction, // Timer one direction pin
    input wire logic second_timer_ext_clock, // Timer two external clock pin
    input wire logic second_timer_ext_direction, // Timer two direction pin
    input wire tecd_pkg::tecd_mode_e first_mode, // Timer one mode
    input wire tecd_pkg::tecd_mode_e second_mode, // Timer two mode
    input wire logic baud_ext_sel, // Take baud clock from timer one pin
    input wire logic baud_int_clock, // Internal baud clock source
    output logic baud_clock_src, // Clock fed to baud-rate generator
    output logic [WIDTH-1:0] first_count, // Timer one count
    output logic [WIDTH-1:0] second_count, // Timer two count
    output logic [1:0] count_step // Per timer: count changed last cycle
);
    import tecd_pkg::*;

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    // Below two bits a count cannot show direction; above 32 bits
    // the wrap arithmetic has not been sized
    generate
        if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
            $error("WIDTH must lie in 2..32");
        end
    endgenerate

    // ==========================================================
    // Pin pairs and modes gathered per timer
    // ==========================================================
    tecd_pins_s pins [2];
    tecd_mode_e mode [2];

    assign pins[0] = '{first_timer_ext_clock, first_timer_ext_direction};
    assign pins[1] = '{second_timer_ext_clock, second_timer_ext_direction};
    assign mode[0] = first_mode;
    assign mode[1] = second_mode;

    // ==========================================================
    // Per-timer pin history, step decision and count
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_timer
            tecd_pins_s prev_r;
            tecd_pins_s prev_nxt;
            logic [WIDTH-1:0] count_r;
            logic [WIDTH-1:0] count_nxt;
            logic step_r;
            logic step_nxt;
            logic clk_edge;
            logic dir_edge;
            logic up;
            logic do_step;

            // ==================================================
            // Pin history
            // ==================================================
            // History resets low, so a pin that is high at release
            // is seen as one edge at the first sample
            always_comb begin
                prev_nxt = pins[g];
            end

            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    prev_r <= TECD_PINS_RST;
                end else begin
                    prev_r <= prev_nxt;
                end
            end

            // ==================================================
            // Edge detection and mode decode
            // ==================================================
            always_comb begin
                clk_edge = pins[g].ext_clock ^ prev_r.ext_clock;
                dir_edge = pins[g].ext_direction ^ prev_r.ext_direction;
                up = 1'b0;
                do_step = 1'b0;
                unique case (mode[g])
                    TECD_MODE_OFF: begin
                        do_step = 1'b0;
                        up = 1'b0;
                    end
                    TECD_MODE_EDGE: begin
                        // Either edge of the clock pin counts
                        do_step = clk_edge;
                        // Direction level sampled alongside the edge
                        up = pins[g].ext_direction;
                    end
                    TECD_MODE_QUAD: begin
                        // Both pins moving in one sample is a lost
                        // step; ignoring it is safer than guessing
                        do_step = clk_edge ^ dir_edge;
                        if (clk_edge) begin
                            // Clock moved: up when it now differs
                            up = pins[g].ext_clock ^
                                pins[g].ext_direction;
                        end else begin
                            // Direction moved: up when it now agrees
                            up = ~(pins[g].ext_clock ^
                                pins[g].ext_direction);
                        end
                    end
                    default: begin
                        // Spare code behaves as off
                        do_step = 1'b0;
                        up = 1'b0;
                    end
                endcase
            end

            // ==================================================
            // Count register
            // ==================================================
            // Wraps silently in both directions, as a 16-bit
            // timer would; no overflow flag is kept here
            always_comb begin
                count_nxt = count_r;
                if (do_step) begin
                    if (up) begin
                        count_nxt = count_r + WIDTH'(1);
                    end else begin
                        count_nxt = count_r - WIDTH'(1);
                    end
                end
            end

            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    count_r <= WIDTH'(TECD_COUNT_RST);
                end else begin
                    count_r <= count_nxt;
                end
            end

            // ==================================================
            // Step flag
            // ==================================================
            always_comb begin
                step_nxt = do_step;
            end

            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    step_r <= 1'b0;
                end else begin
                    step_r <= step_nxt;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Baud-rate generator clock source
    // ==========================================================
    // Registered so the generator sees a clean level; this costs
    // one cycle of delay on the routed clock
    logic baud_nxt;
    logic baud_r;

    always_comb begin
        if (baud_ext_sel) begin
            baud_nxt = first_timer_ext_clock;
        end else begin
            baud_nxt = baud_int_clock;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            baud_r <= 1'b0;
        end else begin
            baud_r <= baud_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign baud_clock_src = baud_r;
    assign first_count = g_timer[0].count_r;
    assign second_count = g_timer[1].count_r;
    assign count_step = {g_timer[1].step_r, g_timer[0].step_r};

endmodule

`default_nettype wire

/* File: test/tecd_src_model.sv */
// Purpose: Pin pair source for one timer, edge or quadrature
// Assumes: Tasks are called from the bench's clocked flow
// Notes: Pins are always driven, as an encoder output would be
`timescale 1ns/1ps
`default_nettype none
module tecd_src_model (
    input wire logic ref_clk, // Peripheral clock
    output var tecd_pkg::tecd_pins_s pins // Clock bit 1, direction bit 0
);
    initial pins = tecd_pkg::TECD_PINS_RST;
    // Gray order: exactly one pin moves per step, so no step is ambiguous
    task automatic quad_step(input logic up);
        @(posedge ref_clk);
        if ((pins[1] == pins[0]) == up) pins[1] <= ~pins[1];
        else pins[0] <= ~pins[0];
    endtask
    // A direction change here moves both pins at once
    task automatic edge_step(input logic up);
        @(posedge ref_clk) pins <= {~pins[1], up};
    endtask
endmodule
`default_nettype wire

/* File: test/tecd_timer_ext_monitor.sv */
// Purpose: Port checks for the timer external clock block
// Assumes: One clock domain, synchronous reset
// Notes: Pins are judged against their value one sample earlier
`timescale 1ns/1ps
`default_nettype none
module tecd_timer_ext_monitor #(parameter int WIDTH = 16) (
    input wire logic ref_clk, // Peripheral clock
    input wire logic rst_n, // Reset, active low
    input wire logic baud_ext_sel, // Baud route select
    input wire logic baud_int_clock, // Internal baud source
    input wire logic baud_clock_src, // Baud clock out
    input wire logic first_timer_ext_clock, // Timer one clock pin
    input wire logic first_timer_ext_direction, // Timer one direction
    input wire logic second_timer_ext_clock, // Timer two clock pin
    input wire logic second_timer_ext_direction, // Timer two direction
    input wire tecd_pkg::tecd_mode_e first_mode, // Timer one mode
    input wire tecd_pkg::tecd_mode_e second_mode, // Timer two mode
    input wire logic [WIDTH-1:0] first_count, // Timer one count
    input wire logic [WIDTH-1:0] second_count, // Timer two count
    input wire logic [1:0] count_step // Step flags
);
    import tecd_pkg::*;
    localparam logic [WIDTH-1:0] UP1 = WIDTH'(1);
    localparam logic [WIDTH-1:0] DN1 = '1;
    wire c1 = first_timer_ext_clock, d1 = first_timer_ext_direction;
    wire c2 = second_timer_ext_clock, d2 = second_timer_ext_direction;
    wire e1 = first_mode == TECD_MODE_EDGE, q1 = first_mode == TECD_MODE_QUAD;
    wire e2 = second_mode == TECD_MODE_EDGE, q2 = second_mode == TECD_MODE_QUAD;
    wire [WIDTH-1:0] k1 = first_count, k2 = second_count;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_one_edge: assert property (e1 && $changed(c1) |=>
        (k1 - $past(k1)) == ($past(d1) ? UP1 : DN1))
        else $error("timer one edge");
    a_two_up: assert property (e2 && $changed(c2) && d2 |=>
        (k2 - $past(k2)) == UP1) else $error("timer two up");
    a_two_down: assert property (e2 && $changed(c2) && !d2 |=>
        ($past(k2) - k2) == UP1) else $error("timer two down");
    a_quad_clock: assert property (q1 && $changed(c1) && $stable(d1) |=>
        (k1 - $past(k1)) == (($past(c1) != $past(d1)) ? UP1 : DN1))
        else $error("quad clock");
    a_quad_dir: assert property (q2 && $changed(d2) && $stable(c2) |=>
        (k2 - $past(k2)) == (($past(c2) == $past(d2)) ? UP1 : DN1))
        else $error("quad dir");
    a_quad_both: assert property (q1 && $changed(c1) && $changed(d1) |=>
        $stable(k1)) else $error("quad both pins");
    a_baud_route: assert property (baud_ext_sel |=>
        baud_clock_src == $past(c1)) else $error("baud route");
    a_baud_int: assert property (!baud_ext_sel |=>
        baud_clock_src == $past(baud_int_clock)) else $error("baud internal");
    a_step_flag: assert property (e1 && $changed(c1) |=>
        count_step[0]) else $error("step flag");
    a_off_idle: assert property (second_mode == TECD_MODE_OFF |=>
        !count_step[1] && $stable(k2)) else $error("off mode moved");
endmodule
bind tecd_timer_ext tecd_timer_ext_monitor #(.WIDTH(WIDTH)) u_mon (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .baud_ext_sel(baud_ext_sel),
    .baud_int_clock(baud_int_clock),
    .baud_clock_src(baud_clock_src),
    .first_timer_ext_clock(first_timer_ext_clock),
    .first_timer_ext_direction(first_timer_ext_direction),
    .second_timer_ext_clock(second_timer_ext_clock),
    .second_timer_ext_direction(second_timer_ext_direction),
    .first_mode(first_mode),
    .second_mode(second_mode),
    .first_count(first_count),
    .second_count(second_count),
    .count_step(count_step)
);
`default_nettype wire

/* File: test/tecd_timer_ext_bench.sv */
// Purpose: Directed bench for the timer external clock block
// Assumes: Baud pin route selected until s_misc picks the internal one; both checked by the monitor
// Notes: Expected counts wrap at 16 bits in both directions
`timescale 1ns/1ps
`default_nettype none
module tecd_timer_ext_bench;
    import tecd_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, baud_ext_sel = 1'b1;
    logic baud_int_clock = 1'b0;
    logic [15:0] first_count, second_count;
    logic baud_clock_src;
    logic [1:0] count_step;
    tecd_mode_e first_mode = TECD_MODE_EDGE, second_mode = TECD_MODE_EDGE;
    tecd_pins_s p1, p2;
    int n_fail = 0, checked = 0;
    always #50 ref_clk = ~ref_clk;
    tecd_src_model u_src1 (.ref_clk(ref_clk), .pins(p1));
    tecd_src_model u_src2 (.ref_clk(ref_clk), .pins(p2));
    tecd_timer_ext u_tecd_timer_ext (.ref_clk(ref_clk), .rst_n(rst_n),
        .first_timer_ext_clock(p1[1]), .first_timer_ext_direction(p1[0]),
        .second_timer_ext_clock(p2[1]), .second_timer_ext_direction(p2[0]),
        .first_mode(first_mode), .second_mode(second_mode),
        .baud_ext_sel(baud_ext_sel), .baud_int_clock(baud_int_clock),
        .baud_clock_src(baud_clock_src), .first_count(first_count),
        .second_count(second_count), .count_step(count_step));
    task automatic cmp(input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) n_fail++;
        if (seen !== exp) $display("[ERR] %0t %h %h", $time, seen, exp);
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic s_edge;
        u_src1.quad_step(1'b0);
        repeat (3) u_src1.edge_step(1'b1);
        repeat (3) u_src2.edge_step(1'b0);
        repeat (2) @(posedge ref_clk);
        cmp(first_count, 16'h0003);
        cmp(second_count, 16'hfffd);
    endtask
    // Starts with both pins of timer one moving at once: no step allowed
    task automatic s_quad;
        first_mode <= TECD_MODE_QUAD;
        second_mode <= TECD_MODE_QUAD;
        u_src1.edge_step(1'b0);
        repeat (3) u_src1.quad_step(1'b1);
        u_src1.quad_step(1'b0);
        repeat (3) u_src2.quad_step(1'b1);
        repeat (2) @(posedge ref_clk);
        cmp(first_count, 16'h0005);
        cmp(second_count, 16'h0000);
    endtask
    // Internal baud route, step flag, and timer two held off
    task automatic s_misc;
        first_mode <= TECD_MODE_EDGE;
        second_mode <= TECD_MODE_OFF;
        baud_ext_sel <= 1'b0;
        @(posedge ref_clk) baud_int_clock <= 1'b1;
        u_src1.edge_step(1'b1);
        @(posedge ref_clk);
        cmp({15'h0000, baud_clock_src}, 16'h0001);
        u_src2.edge_step(1'b1);
        cmp({14'h0000, count_step}, 16'h0001);
        repeat (2) @(posedge ref_clk);
        cmp(first_count, 16'h0006);
        cmp(second_count, 16'h0000);
        cmp({14'h0000, count_step}, 16'h0000);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        s_edge;
        s_quad;
        s_misc;
        tally_and_finish;
    end
    initial begin
        #20us;
        n_fail++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
